// file: pirq_pkg.sv
package pirq_pkg;

	// Bus geometry of the register slave.
	localparam int ADDR_W = 4;
	localparam int DATA_W = 32;
	localparam int BE_W   = 4;

	// Byte offsets of the two flag registers.
	localparam logic [ADDR_W-1:0] OFS_REQUEST_2 = 4'h0;
	localparam logic [ADDR_W-1:0] OFS_REQUEST_3 = 4'h4;

	// Reset values of the flag registers.
	localparam logic [7:0] RST_REQUEST_2 = 8'h00;
	localparam logic [7:0] RST_REQUEST_3 = 8'h00;

	// Byte lane that carries the 8-bit registers.
	localparam int LANE_LOW = 0;

	// Field layout of the second flag register, bit 7 first.
	typedef struct packed {
		logic timer6_period_match_flag;
		logic comparator2_event_flag;
		logic comparator1_event_flag;
		logic nonvolatile_prog_done_flag;
		logic serial_port2_done_flag;
		logic serial_port2_collision_flag;
		logic timer4_period_match_flag;
		logic num_ctrl_osc_rollover_flag;
	} pirq_req2_t;

	// Field layout of the third flag register, bit 7 first.
	typedef struct packed {
		logic osc_fail_flag;
		logic clock_switch_done_flag;
		logic timer3_gate_inactive_flag;
		logic timer3_overflow_flag;
		logic logic_cell4_event_flag;
		logic logic_cell3_event_flag;
		logic logic_cell2_event_flag;
		logic logic_cell1_event_flag;
	} pirq_req3_t;

	// Avalon-MM request from the master.
	typedef struct packed {
		logic              read;
		logic              write;
		logic [ADDR_W-1:0] address;
		logic [DATA_W-1:0] writedata;
		logic [BE_W-1:0]   byteenable;
	} pirq_bus_req_t;

	// Avalon-MM answer to the master.
	typedef struct packed {
		logic [DATA_W-1:0] readdata;
		logic              waitrequest;
	} pirq_bus_rsp_t;

endpackage : pirq_pkg

// file: pirq_flags.sv
`timescale 1ns/1ps
module pirq_flags (
	input  wire logic                   CLK,
	input  wire logic                   RESET,
	input  wire pirq_pkg::pirq_bus_req_t BUS_REQ,
	output      pirq_pkg::pirq_bus_rsp_t BUS_RSP,
	input  wire pirq_pkg::pirq_req2_t    EVENT_2,
	input  wire pirq_pkg::pirq_req3_t    EVENT_3,
	input  wire logic [7:0]              ENABLE_2,
	input  wire logic [7:0]              ENABLE_3,
	output      logic [7:0]              IRQ_PEND_2,
	output      logic [7:0]              IRQ_PEND_3
);
	import pirq_pkg::*;

	////////////////////////////////////////////////////////////////////////////
	// State.

	typedef struct packed {
		pirq_req2_t        flags2;
		pirq_req3_t        flags3;
		logic [7:0]        pend2;
		logic [7:0]        pend3;
		logic              ack;
		logic              waitreq;
		logic [DATA_W-1:0] rdata;
	} pirq_state_t;

	pirq_state_t state;
	pirq_state_t next_state;

	// Read decode, used only by the answer path; the checks below do not call it.
	function automatic logic [DATA_W-1:0] read_word(
		input logic [ADDR_W-1:0] addr,
		input pirq_req2_t        f2,
		input pirq_req3_t        f3
	);
		logic [DATA_W-1:0] word;
		word = '0;
		case (addr)
			OFS_REQUEST_2: word[7:0] = f2;
			OFS_REQUEST_3: word[7:0] = f3;
			default:       word = '0;
		endcase
		return word;
	endfunction : read_word

	logic       take_write;
	logic       lane_on;
	logic [7:0] wbyte;

	// The access completes on the edge where waitrequest is seen low.
	assign take_write = BUS_REQ.write && state.ack;
	assign lane_on    = BUS_REQ.byteenable[LANE_LOW];
	assign wbyte      = BUS_REQ.writedata[7:0];

	////////////////////////////////////////////////////////////////////////////
	// Next state.

	// Events are ORed after the software write so a coincident set is never lost.
	always_comb begin
		next_state = state;
		next_state.ack = 1'b0;
		if ((BUS_REQ.read || BUS_REQ.write) && !state.ack) begin
			next_state.ack   = 1'b1;
			next_state.rdata = read_word(BUS_REQ.address, state.flags2, state.flags3);
		end
		if (take_write && lane_on && BUS_REQ.address == OFS_REQUEST_2) begin
			next_state.flags2 = pirq_req2_t'(wbyte);
		end
		if (take_write && lane_on && BUS_REQ.address == OFS_REQUEST_3) begin
			next_state.flags3 = pirq_req3_t'(wbyte);
		end
		// Setting ignores every enable, as software must see pending events.
		// Each event bit lands on its own flag bit by the struct layout.
		next_state.flags2 = next_state.flags2 | EVENT_2;
		next_state.flags3 = next_state.flags3 | EVENT_3;
		next_state.pend2  = next_state.flags2 & ENABLE_2;
		next_state.pend3  = next_state.flags3 & ENABLE_3;
		// Waitrequest gets its own flop so the bus output has no gate after it.
		next_state.waitreq = !next_state.ack;
	end

	////////////////////////////////////////////////////////////////////////////
	// Registers.

	// Every reset clears the flags; no reset flavour keeps a flag.
	always_ff @(posedge CLK or posedge RESET) begin
		if (RESET) begin
			state.flags2 <= RST_REQUEST_2;
			state.flags3 <= RST_REQUEST_3;
			state.pend2  <= 8'h00;
			state.pend3  <= 8'h00;
			state.ack    <= 1'b0;
			state.waitreq <= 1'b1;
			state.rdata  <= 32'h0000_0000;
		end else begin
			state <= next_state;
		end
	end

	// Outputs come straight from the state flip-flops.
	assign BUS_RSP.readdata    = state.rdata;
	assign BUS_RSP.waitrequest = state.waitreq;
	assign IRQ_PEND_2          = state.pend2;
	assign IRQ_PEND_3          = state.pend3;

	////////////////////////////////////////////////////////////////////////////
	// Checks.

	default clocking cb @(posedge CLK); endclocking
	default disable iff (RESET);

	logic clr2_bit7;
	logic clr2_bit2;
	logic clr3_bit4;

	// A write that accepts a zero into the bit under test.
	assign clr2_bit7 = take_write && lane_on && BUS_REQ.address == OFS_REQUEST_2 && !wbyte[7];
	assign clr2_bit2 = take_write && lane_on && BUS_REQ.address == OFS_REQUEST_2 && !wbyte[2];
	assign clr3_bit4 = take_write && lane_on && BUS_REQ.address == OFS_REQUEST_3 && !wbyte[4];

	sequence s_request;
		(BUS_REQ.read || BUS_REQ.write) && BUS_RSP.waitrequest;
	endsequence

	sequence s_accept;
		!BUS_RSP.waitrequest ##1 BUS_RSP.waitrequest;
	endsequence

	a_bus_accept_bound: assert property (s_request |-> ##[0:1] s_accept)
		else $error("Bus request not accepted within two cycles.");

	a_unmapped_reads_zero: assert property (
		(BUS_REQ.read && !state.ack && BUS_REQ.address != OFS_REQUEST_2
		&& BUS_REQ.address != OFS_REQUEST_3) |=> BUS_RSP.readdata == 32'h0000_0000)
		else $error("Unmapped read did not return zero.");

	a_set_no_enable: assert property (
		(EVENT_3.timer3_gate_inactive_flag && ENABLE_3 == 8'h00)
		|=> state.flags3.timer3_gate_inactive_flag)
		else $error("Event without enable failed to set its flag.");

	a_timer6_held: assert property (
		state.flags2.timer6_period_match_flag && !clr2_bit7
		|=> state.flags2.timer6_period_match_flag)
		else $error("Timer six flag dropped without a software clear.");

	a_timer6_clear: assert property (
		clr2_bit7 && !EVENT_2.timer6_period_match_flag
		|=> !state.flags2.timer6_period_match_flag)
		else $error("Software clear of timer six flag had no effect.");

	a_collision_set: assert property (
		EVENT_2.serial_port2_collision_flag ##1 !clr2_bit2
		|-> state.flags2.serial_port2_collision_flag [*1] ##1 1'b1)
		else $error("Collision flag not set after its event.");

	a_event_map_2: assert property (
		EVENT_2 != 8'h00 |=> (state.flags2 & $past(EVENT_2)) == $past(EVENT_2))
		else $error("A request-2 event did not reach its own bit.");

	a_event_map_3: assert property (
		EVENT_3 != 8'h00 |=> (state.flags3 & $past(EVENT_3)) == $past(EVENT_3))
		else $error("A request-3 event did not reach its own bit.");

	a_set_beats_clear: assert property (
		clr3_bit4 && EVENT_3.timer3_overflow_flag
		|=> state.flags3.timer3_overflow_flag [*1])
		else $error("Coincident event lost to a software clear.");

	a_pend_masked: assert property (
		##1 (IRQ_PEND_2 == (state.flags2 & $past(ENABLE_2))
		&& IRQ_PEND_3 == (state.flags3 & $past(ENABLE_3))))
		else $error("Pending output differs from flag and enable.");

	a_reset_clears: assert property (
		disable iff (1'b0) $fell(RESET) |-> state.flags2 == RST_REQUEST_2
		&& state.flags3 == RST_REQUEST_3)
		else $error("Flags not zero after reset.");

	a_write_readback: assert property (
		take_write && lane_on && BUS_REQ.address == OFS_REQUEST_3 && EVENT_3 == 8'h00
		|=> state.flags3 == $past(wbyte))
		else $error("Written value not stored in request-3.");

	////////////////////////////////////////////////////////////////////////////
	// Per-flag checks.

	logic       wr2_hit;
	logic       wr3_hit;
	logic [7:0] clr2_mask;
	logic [7:0] clr3_mask;
	logic [7:0] wr2_ones;
	logic [7:0] wr3_ones;

	// Bits that an accepted write loads with zero or with one, per register.
	assign wr2_hit   = take_write && lane_on && BUS_REQ.address == OFS_REQUEST_2;
	assign wr3_hit   = take_write && lane_on && BUS_REQ.address == OFS_REQUEST_3;
	assign clr2_mask = wr2_hit ? ~wbyte : 8'h00;
	assign clr3_mask = wr3_hit ? ~wbyte : 8'h00;
	assign wr2_ones  = wr2_hit ? wbyte : 8'h00;
	assign wr3_ones  = wr3_hit ? wbyte : 8'h00;

	a_set_timer6: assert property (
		EVENT_2.timer6_period_match_flag |=> state.flags2.timer6_period_match_flag)
		else $error("Timer six event did not set its flag.");

	a_set_comp2: assert property (
		EVENT_2.comparator2_event_flag |=> state.flags2.comparator2_event_flag)
		else $error("Comparator two event did not set its flag.");

	a_set_comp1: assert property (
		EVENT_2.comparator1_event_flag |=> state.flags2.comparator1_event_flag)
		else $error("Comparator one event did not set its flag.");

	a_set_nvm_done: assert property (
		EVENT_2.nonvolatile_prog_done_flag |=> state.flags2.nonvolatile_prog_done_flag)
		else $error("Programming done event did not set its flag.");

	a_set_port2_done: assert property (
		EVENT_2.serial_port2_done_flag |=> state.flags2.serial_port2_done_flag)
		else $error("Serial port two completion did not set its flag.");

	a_set_collision: assert property (
		EVENT_2.serial_port2_collision_flag
		|=> state.flags2.serial_port2_collision_flag)
		else $error("Collision event did not set its flag.");

	a_set_timer4: assert property (
		EVENT_2.timer4_period_match_flag |=> state.flags2.timer4_period_match_flag)
		else $error("Timer four event did not set its flag.");

	a_set_rollover: assert property (
		EVENT_2.num_ctrl_osc_rollover_flag |=> state.flags2.num_ctrl_osc_rollover_flag)
		else $error("Oscillator rollover did not set its flag.");

	a_set_osc_fail: assert property (
		EVENT_3.osc_fail_flag |=> state.flags3.osc_fail_flag)
		else $error("Oscillator failure did not set its flag.");

	a_set_clk_switch: assert property (
		EVENT_3.clock_switch_done_flag |=> state.flags3.clock_switch_done_flag)
		else $error("Clock switch completion did not set its flag.");

	a_set_gate_idle: assert property (
		EVENT_3.timer3_gate_inactive_flag |=> state.flags3.timer3_gate_inactive_flag)
		else $error("Timer three gate event did not set its flag.");

	a_set_t3_overflow: assert property (
		EVENT_3.timer3_overflow_flag |=> state.flags3.timer3_overflow_flag)
		else $error("Timer three overflow did not set its flag.");

	a_set_cell4: assert property (
		EVENT_3.logic_cell4_event_flag |=> state.flags3.logic_cell4_event_flag)
		else $error("Logic cell four event did not set its flag.");

	a_set_cell3: assert property (
		EVENT_3.logic_cell3_event_flag |=> state.flags3.logic_cell3_event_flag)
		else $error("Logic cell three event did not set its flag.");

	a_set_cell2: assert property (
		EVENT_3.logic_cell2_event_flag |=> state.flags3.logic_cell2_event_flag)
		else $error("Logic cell two event did not set its flag.");

	a_set_cell1: assert property (
		EVENT_3.logic_cell1_event_flag |=> state.flags3.logic_cell1_event_flag)
		else $error("Logic cell one event did not set its flag.");

	// Flags that software must clear may only drop on a write of zero.
	a_collision_held: assert property (
		state.flags2.serial_port2_collision_flag && !clr2_mask[2]
		|=> state.flags2.serial_port2_collision_flag)
		else $error("Collision flag dropped without a software clear.");

	a_timer4_held: assert property (
		state.flags2.timer4_period_match_flag && !clr2_mask[1]
		|=> state.flags2.timer4_period_match_flag)
		else $error("Timer four flag dropped without a software clear.");

	a_port2_held: assert property (
		state.flags2.serial_port2_done_flag && !clr2_mask[3]
		|=> state.flags2.serial_port2_done_flag)
		else $error("Serial port two flag dropped without a software clear.");

	a_t3_overflow_held: assert property (
		state.flags3.timer3_overflow_flag && !clr3_mask[4]
		|=> state.flags3.timer3_overflow_flag)
		else $error("Timer three overflow flag dropped without a software clear.");

	// A write of zero with no event in that cycle must really clear the bit.
	a_collision_clear: assert property (
		clr2_mask[2] && !EVENT_2.serial_port2_collision_flag
		|=> !state.flags2.serial_port2_collision_flag)
		else $error("Software clear of collision flag had no effect.");

	a_timer4_clear: assert property (
		clr2_mask[1] && !EVENT_2.timer4_period_match_flag
		|=> !state.flags2.timer4_period_match_flag)
		else $error("Software clear of timer four flag had no effect.");

	a_port2_clear: assert property (
		clr2_mask[3] && !EVENT_2.serial_port2_done_flag
		|=> !state.flags2.serial_port2_done_flag)
		else $error("Software clear of serial port two flag had no effect.");

	a_t3_overflow_clear: assert property (
		clr3_mask[4] && !EVENT_3.timer3_overflow_flag
		|=> !state.flags3.timer3_overflow_flag)
		else $error("Software clear of timer three overflow flag had no effect.");

	// A flag may rise only from its own event or a software write of one.
	a_no_stray_set_2: assert property (
		##1 ((state.flags2 & ~$past(state.flags2) & ~$past(EVENT_2) & ~$past(wr2_ones))
		== 8'h00))
		else $error("A request-2 flag rose with no cause.");

	a_no_stray_set_3: assert property (
		##1 ((state.flags3 & ~$past(state.flags3) & ~$past(EVENT_3) & ~$past(wr3_ones))
		== 8'h00))
		else $error("A request-3 flag rose with no cause.");

endmodule : pirq_flags

// file: pirq_evsrc.sv
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////
// Event source model: timers, comparators, serial port, clock and logic cells.
// Events come from flops on the system clock, as the block has no synchroniser.
module pirq_evsrc (
	input  wire logic                 CLK,
	input  wire logic                 HOLD,
	input  wire pirq_pkg::pirq_req2_t PAT_2,
	input  wire pirq_pkg::pirq_req3_t PAT_3,
	output      pirq_pkg::pirq_req2_t EVENT_2,
	output      pirq_pkg::pirq_req3_t EVENT_3
);
	import pirq_pkg::*;
	// Events are driven only while asked for, so a level or a pulse both come out.
	always_ff @(posedge CLK) begin
		EVENT_2 <= HOLD ? PAT_2 : '0;
		EVENT_3 <= HOLD ? PAT_3 : '0;
	end
endmodule : pirq_evsrc

// file: pirq_flags_tb.sv
`timescale 1ns/1ps
module pirq_flags_tb;
	import pirq_pkg::*;
	logic CLK = 0, RESET = 1, hold = 0;
	pirq_bus_req_t req = '0;
	pirq_bus_rsp_t rsp;
	pirq_req2_t    ev2, pat2 = '0;
	pirq_req3_t    ev3, pat3 = '0;
	logic [7:0]    en2 = 8'h00, en3 = 8'h00, pnd2, pnd3;
	logic [15:0]   p;
	int            mismatches = 0, num_checks = 0, cyc = 0;
	initial forever #50 CLK = ~CLK;
	pirq_evsrc i_src (.CLK(CLK), .HOLD(hold), .PAT_2(pat2), .PAT_3(pat3),
		.EVENT_2(ev2), .EVENT_3(ev3));
	pirq_flags i_dut (.CLK(CLK), .RESET(RESET), .BUS_REQ(req), .BUS_RSP(rsp),
		.EVENT_2(ev2), .EVENT_3(ev3), .ENABLE_2(en2), .ENABLE_3(en3),
		.IRQ_PEND_2(pnd2), .IRQ_PEND_3(pnd3));
	////////////////////////////////////////////////////////////////
	// Comparison and bus tasks; a request waits an edge first so no signal is driven twice.
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		num_checks++;
		if (g !== e) begin
			mismatches++;
			$display("BAD t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask : chk
	task automatic bus(input logic wr, input logic [3:0] a, input logic [7:0] d,
		output logic [31:0] q);
		@(posedge CLK);
		req.read <= !wr;
		req.write <= wr;
		req.address <= a;
		req.writedata <= {24'h0, d};
		req.byteenable <= 4'hF;
		do @(posedge CLK); while (rsp.waitrequest !== 1'b0);
		q = rsp.readdata;
		req.read <= 1'b0;
		req.write <= 1'b0;
	endtask : bus
	task automatic rd(input logic [3:0] a, input logic [7:0] e);
		logic [31:0] q;
		bus(1'b0, a, 8'h00, q);
		chk(q, {24'h0, e});
	endtask : rd
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		logic [31:0] q;
		bus(1'b1, a, d, q);
	endtask : wr
	task automatic fire(input logic [15:0] v);
		@(posedge CLK);
		hold <= 1'b1;
		{pat3, pat2} <= v;
		@(posedge CLK);
		hold <= 1'b0;
	endtask : fire
	task automatic tally_and_finish;
		$display("checks=%0d mismatches=%0d", num_checks, mismatches);
		if (mismatches == 0 && num_checks > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask : tally_and_finish
	////////////////////////////////////////////////////////////////
	// A hang is cut short well beyond the few hundred cycles the run needs.
	always @(posedge CLK) begin
		cyc++;
		if (cyc == 5000) begin
			mismatches++;
			tally_and_finish();
		end
	end
	// Main sequence; enables stay low while flags are walked to show they set anyway.
	initial begin
		repeat (2) @(posedge CLK);
		RESET <= 1'b0;
		rd(OFS_REQUEST_2, RST_REQUEST_2);
		rd(OFS_REQUEST_3, RST_REQUEST_3);
		for (int i = 0; i < 16; i++) begin
			p = 16'h0001 << i;
			fire(p);
			rd(OFS_REQUEST_2, p[7:0]);
			rd(OFS_REQUEST_3, p[15:8]);
			wr(i < 8 ? OFS_REQUEST_2 : OFS_REQUEST_3, 8'h00);
			rd(i < 8 ? OFS_REQUEST_2 : OFS_REQUEST_3, 8'h00);
		end
		wr(OFS_REQUEST_2, 8'hA5);
		rd(OFS_REQUEST_2, 8'hA5);
		// An event held through a clearing write must win.
		@(posedge CLK);
		hold <= 1'b1;
		{pat3, pat2} <= 16'h1080;
		wr(OFS_REQUEST_2, 8'h00);
		wr(OFS_REQUEST_3, 8'h00);
		hold <= 1'b0;
		rd(OFS_REQUEST_2, 8'h80);
		rd(OFS_REQUEST_3, 8'h10);
		wr(OFS_REQUEST_2, 8'h00);
		wr(OFS_REQUEST_3, 8'h00);
		en2 <= 8'h0F;
		en3 <= 8'hF0;
		wr(OFS_REQUEST_2, 8'h33);
		wr(OFS_REQUEST_3, 8'h33);
		repeat (3) @(posedge CLK);
		chk({24'h0, pnd2}, 32'h03);
		chk({24'h0, pnd3}, 32'h30);
		wr(4'h8, 8'hFF);
		rd(4'h8, 8'h00);
		RESET <= 1'b1;
		repeat (2) @(posedge CLK);
		RESET <= 1'b0;
		chk({16'h0, pnd3, pnd2}, 32'h0);
		rd(OFS_REQUEST_2, 8'h00);
		rd(OFS_REQUEST_3, 8'h00);
		tally_and_finish();
	end
endmodule : pirq_flags_tb
